/* lesc_params.svh */
// Purpose: Constants for the link error statistics counters
// Assumes: Included by bare name
// Notes:   Widths, saturation limits and reason codes
`ifndef LESC_PARAMS_SVH
`define LESC_PARAMS_SVH

`define LESC_BG_WIDTH        16
`define LESC_BG_MAX          16'hFFFF
`define LESC_ST_WIDTH        8
`define LESC_ST_MAX          8'hFF
`define LESC_TH_WIDTH        3
`define LESC_TH_MAX          3'h7
`define LESC_REASON_WIDTH    5
`define LESC_NAK_HDR_BCC     5'h01
`define LESC_NAK_DATA_BCC    5'h02
`define LESC_NAK_REP         5'h03
`define LESC_NAK_BUF_TEMP    5'h08
`define LESC_NAK_OVERRUN     5'h09
`define LESC_NAK_BUF_SMALL   5'h10
`define LESC_NAK_HDR_FORMAT  5'h11
`define LESC_SEL_NO_REPLY_SELECT_FLAG_BIT    0
`define LESC_SEL_INCOMPLETE_REPLY_SELECT_FLAG_BIT    1
`define LESC_RSE_OVRN_BIT    0
`define LESC_RSE_HFMT_BIT    1
`define LESC_RSE_ADDR_BIT    2
`define LESC_RSE_STRM_BIT    3
`define LESC_LSE_NAKS_BIT    0
`define LESC_LSE_NAKN_BIT    1
`define LESC_LSE_UNDR_BIT    2
`define LESC_LSE_HFMT_BIT    3

`endif

/* lesc_pkg.sv */
// Purpose: Types for the link error statistics counters
// Assumes: Nothing
// Notes:   Protocol state and station role encodings
package lesc_pkg;
	typedef enum logic [1:0] {
		LESC_ST_HALT,
		LESC_ST_ISTRT,
		LESC_ST_ASTRT,
		LESC_ST_RUN
	} lesc_proto_t;

	typedef enum logic [1:0] {
		LESC_ROLE_P2P_FDX,
		LESC_ROLE_P2P_HDX,
		LESC_ROLE_MP_CTRL,
		LESC_ROLE_MP_TRIB
	} lesc_role_t;
endpackage

/* lesc_thresh.sv */
// Purpose: One set of 3-bit threshold counters (transmit, receive, selection)
// Assumes: Events are one-cycle pulses on the controller clock
// Notes:   Report pulses when a counter sits at its maximum
`include "lesc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lesc_thresh
	import lesc_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      enter_i,
	input  wire logic                      run_i,
	input  wire logic                      tx_inc_i,
	input  wire logic                      tx_clr_i,
	input  wire logic                      rx_inc_i,
	input  wire logic                      rx_clr_i,
	input  wire logic                      sel_inc_i,
	input  wire logic                      sel_clr_i,
	output logic [`LESC_TH_WIDTH-1:0]      tx_q,
	output logic [`LESC_TH_WIDTH-1:0]      rx_q,
	output logic [`LESC_TH_WIDTH-1:0]      sel_q,
	output logic [2:0]                     report_q
);
	logic [2:0] at_max;

	assign at_max = {sel_q == `LESC_TH_MAX, rx_q == `LESC_TH_MAX, tx_q == `LESC_TH_MAX};

	// Saturating step; a clear request or a run-state report wins
	function automatic logic [`LESC_TH_WIDTH-1:0] th_next(
		input logic [`LESC_TH_WIDTH-1:0] cur,
		input logic inc,
		input logic clr,
		input logic rep_clr
	);
		if (clr || rep_clr)
			return '0;
		if (inc && cur != `LESC_TH_MAX)
			return cur + `LESC_TH_WIDTH'(1);
		return cur;
	endfunction

	// Report each cycle at the maximum outside run only once: counter is held, so pulse on arrival
	logic [2:0] at_max_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			at_max_q <= '0;
		else
			at_max_q <= at_max;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			report_q <= '0;
		else
			// In run the counter clears one edge after the report, so mask the second cycle at the maximum
			report_q <= run_i ? (at_max & ~report_q) : (at_max & ~at_max_q);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_q  <= '0;
			rx_q  <= '0;
			sel_q <= '0;
		end else begin
			tx_q  <= th_next(tx_q, tx_inc_i, tx_clr_i || enter_i, run_i && report_q[0]);
			rx_q  <= th_next(rx_q, rx_inc_i, rx_clr_i || enter_i, run_i && report_q[1]);
			sel_q <= th_next(sel_q, sel_inc_i, sel_clr_i, run_i && report_q[2]);
		end
	end
endmodule
`default_nettype wire

/* lesc_top.sv */
// Purpose: Link error statistics and threshold counters of a multipoint link controller
// Assumes: All event inputs are one-cycle pulses from logic on MCLK_I
// Notes:   Threshold sets are indexed by tributary; one shared set of station counters
`include "lesc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lesc_top
	import lesc_pkg::*;
#(
	parameter int TRIB_COUNT = 8,
	parameter int TRIB_W     = 3
)(
	input  wire logic                          MCLK_I,
	input  wire logic                          RESET_N_I,
	input  wire logic                          MASTER_CLEAR_I,
	input  wire logic                          READ_CLEAR_GLOBAL_I,
	input  wire lesc_role_t                    ROLE_I,
	input  wire lesc_proto_t                   PROTO_STATE_I,
	input  wire logic                          STATE_ENTER_I,
	input  wire logic [TRIB_W-1:0]             TRIB_SEL_I,
	input  wire logic                          SELECT_START_I,
	input  wire logic                          SELECT_EXPIRE_I,
	input  wire logic                          VALID_CTRL_RX_I,
	input  wire logic                          VALID_HDR_RX_I,
	input  wire logic                          CARRIER_I,
	input  wire logic                          SYNC_RX_I,
	input  wire logic                          SOH_ENQ_DLE_RX_I,
	input  wire logic                          DATA_TX_I,
	input  wire logic                          DATA_RETX_I,
	input  wire logic                          DATA_RX_GOOD_I,
	input  wire logic                          SELECT_TX_I,
	input  wire logic                          SELECT_RX_I,
	input  wire logic                          NAK_RX_I,
	input  wire logic [`LESC_REASON_WIDTH-1:0] NAK_RX_REASON_I,
	input  wire logic                          NAK_TX_I,
	input  wire logic [`LESC_REASON_WIDTH-1:0] NAK_TX_REASON_I,
	input  wire logic                          HDR_FORMAT_ERR_I,
	input  wire logic                          ADDR_MISMATCH_I,
	input  wire logic                          STREAMING_I,
	input  wire logic                          RX_OVERRUN_I,
	input  wire logic                          OVERRUN_IN_HDR_I,
	input  wire logic                          TX_UNDERRUN_I,
	input  wire logic                          MAINT_HDR_BCC_I,
	input  wire logic                          FOREIGN_HDR_BCC_I,
	input  wire logic                          MAINT_DATA_BCC_I,
	input  wire logic                          STRT_TX_I,
	input  wire logic                          STACK_TX_I,
	input  wire logic                          REP_TX_I,
	input  wire logic                          ACK_NEW_I,
	input  wire logic                          GOOD_CTRL_RX_I,
	input  wire logic                          GOOD_DATA_RX_I,
	output logic                               OVERRUN_NAK_REQ_O,
	output logic [`LESC_ST_WIDTH-1:0]          SEL_TIMEOUT_CNT_O,
	output logic [1:0]                         SEL_TIMEOUT_FLAGS_O,
	output logic [`LESC_BG_WIDTH-1:0]          DATA_TX_CNT_O,
	output logic [`LESC_BG_WIDTH-1:0]          DATA_RX_CNT_O,
	output logic [`LESC_BG_WIDTH-1:0]          SEL_INTERVAL_CNT_O,
	output logic [`LESC_ST_WIDTH-1:0]          REMOTE_ERR_CNT_O,
	output logic [3:0]                         REMOTE_ERR_FLAGS_O,
	output logic [`LESC_ST_WIDTH-1:0]          LOCAL_ERR_CNT_O,
	output logic [3:0]                         LOCAL_ERR_FLAGS_O,
	output logic [`LESC_ST_WIDTH-1:0]          GLOBAL_HDR_BCC_CNT_O,
	output logic [`LESC_ST_WIDTH-1:0]          MAINT_DATA_BCC_CNT_O,
	output logic                               THRESH_REPORT_O,
	output logic [2:0]                         THRESH_KIND_O,
	output logic [TRIB_W-1:0]                  THRESH_TRIB_O
);
	logic                      sel_keeper;
	logic                      in_run;
	logic                      global_clr;
	logic                      activity_q;
	logic                      attempt;
	logic                      rx_nak_ovrn;
	logic                      rx_nak_hfmt;
	logic                      remote_hit;
	logic                      local_hit;
	logic                      nak_ok;
	logic                      tx_nak_counts;
	logic [TRIB_W-1:0]         trib;
	logic [TRIB_COUNT-1:0][2:0] rep_vec;

	// Saturating increment used by the 16-bit background statistics counters
	function automatic logic [`LESC_BG_WIDTH-1:0] sat_inc(
		input logic [`LESC_BG_WIDTH-1:0] cur,
		input logic [`LESC_BG_WIDTH-1:0] lim
	);
		return (cur == lim) ? cur : cur + `LESC_BG_WIDTH'(1);
	endfunction

	// Saturating increment for the 8-bit station counters
	function automatic logic [`LESC_ST_WIDTH-1:0] sat_inc8(
		input logic [`LESC_ST_WIDTH-1:0] cur
	);
		return (cur == `LESC_ST_MAX) ? cur : cur + `LESC_ST_WIDTH'(1);
	endfunction

	assign sel_keeper = (ROLE_I == LESC_ROLE_P2P_HDX) || (ROLE_I == LESC_ROLE_MP_CTRL);
	assign in_run     = (PROTO_STATE_I == LESC_ST_RUN);
	assign global_clr = MASTER_CLEAR_I || READ_CLEAR_GLOBAL_I;
	assign attempt    = CARRIER_I || SYNC_RX_I || SOH_ENQ_DLE_RX_I;
	// Point-to-point stations always use set zero
	assign trib       = (ROLE_I == LESC_ROLE_P2P_FDX || ROLE_I == LESC_ROLE_P2P_HDX) ? '0 : TRIB_SEL_I;

	assign rx_nak_ovrn = NAK_RX_I && (NAK_RX_REASON_I == `LESC_NAK_OVERRUN);
	assign rx_nak_hfmt = NAK_RX_I && (NAK_RX_REASON_I == `LESC_NAK_HDR_FORMAT);
	assign remote_hit  = rx_nak_ovrn || HDR_FORMAT_ERR_I || (ADDR_MISMATCH_I && ROLE_I == LESC_ROLE_MP_CTRL)
			|| STREAMING_I;
	// No NAK outside run or when a tributary overruns within a header
	assign nak_ok      = in_run && !(ROLE_I == LESC_ROLE_MP_TRIB && OVERRUN_IN_HDR_I);
	assign local_hit   = RX_OVERRUN_I || TX_UNDERRUN_I || rx_nak_hfmt;
	assign tx_nak_counts = NAK_TX_I && (NAK_TX_REASON_I == `LESC_NAK_HDR_BCC || NAK_TX_REASON_I == `LESC_NAK_DATA_BCC
			|| NAK_TX_REASON_I == `LESC_NAK_REP || NAK_TX_REASON_I == `LESC_NAK_BUF_TEMP
			|| NAK_TX_REASON_I == `LESC_NAK_OVERRUN || NAK_TX_REASON_I == `LESC_NAK_BUF_SMALL);

	// Reply activity seen within the current selection interval
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			activity_q <= 1'b0;
		else if (SELECT_START_I || SELECT_EXPIRE_I || MASTER_CLEAR_I)
			activity_q <= 1'b0;
		else if (VALID_CTRL_RX_I || VALID_HDR_RX_I || attempt)
			activity_q <= 1'b1;
	end

	// Selection timeout counter and cause flags
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			SEL_TIMEOUT_CNT_O   <= '0;
			SEL_TIMEOUT_FLAGS_O <= '0;
		end else if (MASTER_CLEAR_I) begin
			SEL_TIMEOUT_CNT_O   <= '0;
			SEL_TIMEOUT_FLAGS_O <= '0;
		end else if (SELECT_EXPIRE_I && sel_keeper) begin
			SEL_TIMEOUT_CNT_O <= sat_inc8(SEL_TIMEOUT_CNT_O);
			// Activity in this very cycle still counts as a reply
			if (activity_q || VALID_CTRL_RX_I || VALID_HDR_RX_I || attempt)
				SEL_TIMEOUT_FLAGS_O[`LESC_SEL_INCOMPLETE_REPLY_SELECT_FLAG_BIT] <= 1'b1;
			else
				SEL_TIMEOUT_FLAGS_O[`LESC_SEL_NO_REPLY_SELECT_FLAG_BIT] <= 1'b1;
		end
	end

	// Background statistics counters
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			DATA_TX_CNT_O      <= '0;
			DATA_RX_CNT_O      <= '0;
			SEL_INTERVAL_CNT_O <= '0;
		end else if (MASTER_CLEAR_I) begin
			DATA_TX_CNT_O      <= '0;
			DATA_RX_CNT_O      <= '0;
			SEL_INTERVAL_CNT_O <= '0;
		end else begin
			if (DATA_TX_I && !DATA_RETX_I)
				DATA_TX_CNT_O <= sat_inc(DATA_TX_CNT_O, `LESC_BG_MAX);
			if (DATA_RX_GOOD_I)
				DATA_RX_CNT_O <= sat_inc(DATA_RX_CNT_O, `LESC_BG_MAX);
			if (SELECT_TX_I && sel_keeper)
				SEL_INTERVAL_CNT_O <= sat_inc(SEL_INTERVAL_CNT_O, `LESC_BG_MAX);
		end
	end

	// Remote station errors; an event in the clearing cycle is kept
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			REMOTE_ERR_CNT_O   <= '0;
			REMOTE_ERR_FLAGS_O <= '0;
		end else begin
			if (remote_hit)
				REMOTE_ERR_CNT_O <= global_clr ? 8'h01 : sat_inc8(REMOTE_ERR_CNT_O);
			else if (global_clr)
				REMOTE_ERR_CNT_O <= '0;
			REMOTE_ERR_FLAGS_O <= (global_clr ? 4'h0 : REMOTE_ERR_FLAGS_O) | {
				STREAMING_I,
				ADDR_MISMATCH_I && ROLE_I == LESC_ROLE_MP_CTRL,
				HDR_FORMAT_ERR_I,
				rx_nak_ovrn};
		end
	end

	// Local station errors and the overrun NAK request
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			LOCAL_ERR_CNT_O   <= '0;
			LOCAL_ERR_FLAGS_O <= '0;
		end else begin
			if (local_hit)
				LOCAL_ERR_CNT_O <= global_clr ? 8'h01 : sat_inc8(LOCAL_ERR_CNT_O);
			else if (global_clr)
				LOCAL_ERR_CNT_O <= '0;
			LOCAL_ERR_FLAGS_O <= (global_clr ? 4'h0 : LOCAL_ERR_FLAGS_O) | {
				rx_nak_hfmt,
				TX_UNDERRUN_I,
				RX_OVERRUN_I && !nak_ok,
				RX_OVERRUN_I && nak_ok};
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			OVERRUN_NAK_REQ_O <= 1'b0;
		else
			OVERRUN_NAK_REQ_O <= RX_OVERRUN_I && nak_ok;
	end

	// Global header and maintenance data check counters
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			GLOBAL_HDR_BCC_CNT_O <= '0;
			MAINT_DATA_BCC_CNT_O <= '0;
		end else begin
			if (MAINT_HDR_BCC_I || FOREIGN_HDR_BCC_I)
				GLOBAL_HDR_BCC_CNT_O <= global_clr ? 8'h01 : sat_inc8(GLOBAL_HDR_BCC_CNT_O);
			else if (global_clr)
				GLOBAL_HDR_BCC_CNT_O <= '0;
			if (MAINT_DATA_BCC_I)
				MAINT_DATA_BCC_CNT_O <= global_clr ? 8'h01 : sat_inc8(MAINT_DATA_BCC_CNT_O);
			else if (global_clr)
				MAINT_DATA_BCC_CNT_O <= '0;
		end
	end

	// One threshold set per tributary; events steer to the selected set
	for (genvar g = 0; g < TRIB_COUNT; g++) begin : g_th
		logic hit;
		assign hit = (trib == TRIB_W'(g));
		lesc_thresh u_th (
			.clk_i     (MCLK_I),
			.rst_n_i   (RESET_N_I),
			.enter_i   (MASTER_CLEAR_I || (STATE_ENTER_I && PROTO_STATE_I != LESC_ST_HALT && hit)),
			.run_i     (in_run),
			.tx_inc_i  (hit && ((STRT_TX_I && PROTO_STATE_I == LESC_ST_ISTRT)
					|| (STACK_TX_I && PROTO_STATE_I == LESC_ST_ASTRT)
					|| (in_run && ((NAK_RX_I && NAK_RX_REASON_I != `LESC_NAK_REP) || REP_TX_I)))),
			.tx_clr_i  (hit && in_run && ACK_NEW_I),
			.rx_inc_i  (hit && tx_nak_counts),
			.rx_clr_i  (hit && (GOOD_CTRL_RX_I || GOOD_DATA_RX_I)),
			.sel_inc_i (hit && sel_keeper && SELECT_EXPIRE_I),
			.sel_clr_i (MASTER_CLEAR_I || (hit && SELECT_RX_I)),
			.tx_q      (),
			.rx_q      (),
			.sel_q     (),
			.report_q  (rep_vec[g])
		);
	end

	// Report the lowest tributary with a pending threshold event
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			THRESH_REPORT_O <= 1'b0;
			THRESH_KIND_O   <= '0;
			THRESH_TRIB_O   <= '0;
		end else begin
			THRESH_REPORT_O <= 1'b0;
			THRESH_KIND_O   <= '0;
			THRESH_TRIB_O   <= '0;
			for (int i = TRIB_COUNT - 1; i >= 0; i--) begin
				if (|rep_vec[i]) begin
					THRESH_REPORT_O <= 1'b1;
					THRESH_KIND_O   <= rep_vec[i];
					THRESH_TRIB_O   <= TRIB_W'(i);
				end
			end
		end
	end
endmodule
`default_nettype wire

/* lesc_remote.sv */
// Purpose: Far-end station model driving line-side events into the counters
// Assumes: Tasks are entered 1 ns after a rising edge
// Notes:   Released reason lines show the inverse value, never the stale one
`include "lesc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lesc_remote
	import lesc_pkg::*;
(
	input  wire logic	clk_i,
	output logic	nak_o,
	output logic [`LESC_REASON_WIDTH-1:0]	reason_o,
	output logic	carrier_o,
	output logic	sync_o,
	output logic	soh_o,
	output logic	ctrl_o,
	output logic	hdr_o
);
	initial begin
		{nak_o, carrier_o, sync_o, soh_o, ctrl_o, hdr_o} = 6'h00;
		reason_o = '0;
	end
	// NAK frame arriving from the remote with its reason code
	task automatic nak(input logic [`LESC_REASON_WIDTH-1:0] code);
		nak_o = 1'b1;
		reason_o = code;
		@(posedge clk_i);
		#1 nak_o = 1'b0;
		reason_o = ~code;
		@(posedge clk_i);
		#1;
	endtask
	// Reply activity: carrier, sync, SOH/ENQ/DLE, valid control, valid header
	task automatic attempt(input int k);
		{hdr_o, ctrl_o, soh_o, sync_o, carrier_o} = 5'h01 << k;
		@(posedge clk_i);
		#1 {hdr_o, ctrl_o, soh_o, sync_o, carrier_o} = 5'h00;
		@(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

/* lesc_checker.sv */
// Purpose: Concurrent checks on the statistics counter ports
// Assumes: Bound to lesc_top
// Notes:   Single clock domain, disabled during reset
`include "lesc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lesc_checker
	import lesc_pkg::*;
(
	input wire logic	MCLK_I,
	input wire logic	RESET_N_I,
	input wire logic	MASTER_CLEAR_I,
	input wire lesc_role_t	ROLE_I,
	input wire lesc_proto_t	PROTO_STATE_I,
	input wire logic	SELECT_EXPIRE_I,
	input wire logic	DATA_TX_I,
	input wire logic	DATA_RETX_I,
	input wire logic	DATA_RX_GOOD_I,
	input wire logic	NAK_RX_I,
	input wire logic [`LESC_REASON_WIDTH-1:0]	NAK_RX_REASON_I,
	input wire logic	RX_OVERRUN_I,
	input wire logic	OVERRUN_IN_HDR_I,
	input wire logic	TX_UNDERRUN_I,
	input wire logic	OVERRUN_NAK_REQ_O,
	input wire logic [7:0]	SEL_TIMEOUT_CNT_O,
	input wire logic [1:0]	SEL_TIMEOUT_FLAGS_O,
	input wire logic [15:0]	DATA_TX_CNT_O,
	input wire logic [15:0]	DATA_RX_CNT_O,
	input wire logic [15:0]	SEL_INTERVAL_CNT_O,
	input wire logic [7:0]	REMOTE_ERR_CNT_O,
	input wire logic [3:0]	REMOTE_ERR_FLAGS_O,
	input wire logic [7:0]	LOCAL_ERR_CNT_O,
	input wire logic [3:0]	LOCAL_ERR_FLAGS_O,
	input wire logic	THRESH_REPORT_O,
	input wire logic [2:0]	THRESH_KIND_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);
	logic sel_role;
	assign sel_role = (ROLE_I == LESC_ROLE_P2P_HDX) || (ROLE_I == LESC_ROLE_MP_CTRL);
	sequence ovr_run_s;
		RX_OVERRUN_I && PROTO_STATE_I == LESC_ST_RUN && !MASTER_CLEAR_I
			&& !(ROLE_I == LESC_ROLE_MP_TRIB && OVERRUN_IN_HDR_I);
	endsequence
	sequence req_pulse_s;
		OVERRUN_NAK_REQ_O ##1 !OVERRUN_NAK_REQ_O;
	endsequence
	nak_request_a: assert property (ovr_run_s ##1 !RX_OVERRUN_I |-> req_pulse_s)
		else $error("overrun in run gave no single NAK request");
	tx_count_step_a: assert property (DATA_TX_I && !DATA_RETX_I && !MASTER_CLEAR_I && DATA_TX_CNT_O != 16'hFFFF
		|=> DATA_TX_CNT_O == $past(DATA_TX_CNT_O) + 16'h1) else $error("sent count did not step");
	retx_hold_a: assert property ((!DATA_TX_I || DATA_RETX_I) && !MASTER_CLEAR_I |=> $stable(DATA_TX_CNT_O))
		else $error("sent count moved without a fresh message");
	rx_count_sat_a: assert property (DATA_RX_CNT_O == 16'hFFFF && !MASTER_CLEAR_I |=> DATA_RX_CNT_O == 16'hFFFF)
		else $error("received count left saturation");
	sel_role_gate_a: assert property (!sel_role && !MASTER_CLEAR_I
		|=> $stable(SEL_INTERVAL_CNT_O) && $stable(SEL_TIMEOUT_CNT_O)) else $error("selection counts moved");
	sel_timeout_mark_a: assert property (SELECT_EXPIRE_I && sel_role
		|=> SEL_TIMEOUT_CNT_O != 8'h00 && SEL_TIMEOUT_FLAGS_O != 2'b00) else $error("timeout not recorded");
	remote_overrun_a: assert property (NAK_RX_I && NAK_RX_REASON_I == `LESC_NAK_OVERRUN && !MASTER_CLEAR_I
		|=> REMOTE_ERR_FLAGS_O[0] && REMOTE_ERR_CNT_O != 8'h00) else $error("remote overrun missed");
	underrun_mark_a: assert property (TX_UNDERRUN_I && !MASTER_CLEAR_I
		|=> LOCAL_ERR_FLAGS_O[2] && LOCAL_ERR_CNT_O != 8'h00) else $error("underrun missed");
	master_clear_a: assert property (MASTER_CLEAR_I && !DATA_TX_I && !DATA_RX_GOOD_I
		|=> DATA_TX_CNT_O == 16'h0 && DATA_RX_CNT_O == 16'h0) else $error("master clear left counts");
	report_kind_a: assert property (THRESH_REPORT_O |-> THRESH_KIND_O != 3'h0)
		else $error("report without a kind");
endmodule
`default_nettype wire

/* lesc_top_tb.sv */
// Purpose: Self-checking bench for the link error statistics counters
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Long saturation run kept last, it dominates run time
`include "lesc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lesc_top_tb;
	import lesc_pkg::*;
	logic MCLK_I = 0, RESET_N_I = 0, MASTER_CLEAR_I = 0, READ_CLEAR_GLOBAL_I = 0, STATE_ENTER_I = 0;
	logic SELECT_START_I = 0, SELECT_EXPIRE_I = 0, DATA_TX_I = 0, DATA_RETX_I = 0, DATA_RX_GOOD_I = 0;
	logic SELECT_TX_I = 0, SELECT_RX_I = 0, NAK_TX_I = 0, HDR_FORMAT_ERR_I = 0, ADDR_MISMATCH_I = 0;
	logic STREAMING_I = 0, RX_OVERRUN_I = 0, OVERRUN_IN_HDR_I = 0, TX_UNDERRUN_I = 0, MAINT_HDR_BCC_I = 0;
	logic FOREIGN_HDR_BCC_I = 0, MAINT_DATA_BCC_I = 0, STRT_TX_I = 0, STACK_TX_I = 0, REP_TX_I = 0;
	logic ACK_NEW_I = 0, GOOD_CTRL_RX_I = 0, GOOD_DATA_RX_I = 0;
	logic [4:0] NAK_TX_REASON_I = 0, NAK_RX_REASON_I;
	logic [2:0] TRIB_SEL_I = 0, THRESH_KIND_O, THRESH_TRIB_O, rep_kind, rep_trib;
	lesc_role_t ROLE_I = LESC_ROLE_P2P_FDX;
	lesc_proto_t PROTO_STATE_I = LESC_ST_HALT;
	logic NAK_RX_I, CARRIER_I, SYNC_RX_I, SOH_ENQ_DLE_RX_I, VALID_CTRL_RX_I, VALID_HDR_RX_I;
	logic OVERRUN_NAK_REQ_O, THRESH_REPORT_O;
	logic [1:0] SEL_TIMEOUT_FLAGS_O;
	logic [3:0] REMOTE_ERR_FLAGS_O, LOCAL_ERR_FLAGS_O;
	logic [7:0] SEL_TIMEOUT_CNT_O, REMOTE_ERR_CNT_O, LOCAL_ERR_CNT_O, GLOBAL_HDR_BCC_CNT_O, MAINT_DATA_BCC_CNT_O;
	logic [15:0] DATA_TX_CNT_O, DATA_RX_CNT_O, SEL_INTERVAL_CNT_O;
	int n_fail = 0, n_checks = 0, n_rep = 0, n_req = 0, r;
	lesc_top u_dut (.*);
	lesc_remote u_far (.clk_i(MCLK_I), .nak_o(NAK_RX_I), .reason_o(NAK_RX_REASON_I), .carrier_o(CARRIER_I),
		.sync_o(SYNC_RX_I), .soh_o(SOH_ENQ_DLE_RX_I), .ctrl_o(VALID_CTRL_RX_I), .hdr_o(VALID_HDR_RX_I));
	always #2 MCLK_I = ~MCLK_I;
	// Pulses are counted here since they stand for one cycle only
	always @(posedge MCLK_I) begin
		if (THRESH_REPORT_O === 1'b1) begin
			n_rep++;
			rep_kind = THRESH_KIND_O;
			rep_trib = THRESH_TRIB_O;
		end
		if (OVERRUN_NAK_REQ_O === 1'b1)
			n_req++;
	end
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK_I);
		#1;
	endtask
	// A trailing idle cycle keeps two raises of one strobe apart
	task automatic pulse(ref logic s, input int n);
		s = 1'b1;
		repeat (n) @(posedge MCLK_I);
		#1 s = 1'b0;
		cyc(1);
	endtask
	task automatic complete_run();
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_counts();
		pulse(DATA_TX_I, 3);
		DATA_RETX_I = 1'b1;
		pulse(DATA_TX_I, 2);
		DATA_RETX_I = 1'b0;
		chk(DATA_TX_CNT_O, 24'h3);
		pulse(DATA_RX_GOOD_I, 1);
		chk(DATA_RX_CNT_O, 24'h1);
		pulse(SELECT_TX_I, 1);
		pulse(SELECT_EXPIRE_I, 1);
		chk({SEL_INTERVAL_CNT_O, SEL_TIMEOUT_CNT_O}, 24'h0);
		ROLE_I = LESC_ROLE_P2P_HDX;
		pulse(SELECT_TX_I, 2);
		chk(SEL_INTERVAL_CNT_O, 24'h2);
	endtask
	task automatic t_select();
		ROLE_I = LESC_ROLE_MP_CTRL;
		for (int k = 0; k < 6; k++) begin
			pulse(MASTER_CLEAR_I, 1);
			pulse(SELECT_START_I, 1);
			if (k < 5)
				u_far.attempt(k);
			pulse(SELECT_EXPIRE_I, 1);
			chk(SEL_TIMEOUT_FLAGS_O, (k < 5) ? 24'h2 : 24'h1);
			chk(SEL_TIMEOUT_CNT_O, 24'h1);
		end
		TRIB_SEL_I = 3'h5;
		r = n_rep;
		pulse(SELECT_EXPIRE_I, 6);
		pulse(SELECT_RX_I, 1);
		pulse(SELECT_EXPIRE_I, 6);
		cyc(2);
		chk(24'(n_rep - r), 24'h0);
		pulse(SELECT_EXPIRE_I, 1);
		cyc(2);
		chk(24'(n_rep - r), 24'h1);
		chk({rep_kind, rep_trib}, 24'h25);
	endtask
	task automatic t_station();
		u_far.nak(`LESC_NAK_OVERRUN);
		pulse(HDR_FORMAT_ERR_I, 1);
		pulse(ADDR_MISMATCH_I, 1);
		pulse(STREAMING_I, 1);
		chk({REMOTE_ERR_CNT_O, REMOTE_ERR_FLAGS_O}, 24'h4F);
		PROTO_STATE_I = LESC_ST_RUN;
		r = n_req;
		pulse(RX_OVERRUN_I, 1);
		PROTO_STATE_I = LESC_ST_HALT;
		pulse(RX_OVERRUN_I, 1);
		pulse(TX_UNDERRUN_I, 1);
		u_far.nak(`LESC_NAK_HDR_FORMAT);
		chk({LOCAL_ERR_CNT_O, LOCAL_ERR_FLAGS_O}, 24'h4F);
		ROLE_I = LESC_ROLE_MP_TRIB;
		PROTO_STATE_I = LESC_ST_RUN;
		OVERRUN_IN_HDR_I = 1'b1;
		pulse(RX_OVERRUN_I, 1);
		OVERRUN_IN_HDR_I = 1'b0;
		PROTO_STATE_I = LESC_ST_HALT;
		chk({LOCAL_ERR_CNT_O, LOCAL_ERR_FLAGS_O}, 24'h5F);
		chk(24'(n_req - r), 24'h1);
		pulse(MAINT_HDR_BCC_I, 1);
		pulse(FOREIGN_HDR_BCC_I, 1);
		chk(GLOBAL_HDR_BCC_CNT_O, 24'h2);
		pulse(MAINT_DATA_BCC_I, 260);
		chk(MAINT_DATA_BCC_CNT_O, 24'hFF);
		pulse(DATA_TX_I, 3);
		pulse(READ_CLEAR_GLOBAL_I, 1);
		chk({REMOTE_ERR_CNT_O, LOCAL_ERR_CNT_O, GLOBAL_HDR_BCC_CNT_O}, 24'h0);
		chk({MAINT_DATA_BCC_CNT_O, DATA_TX_CNT_O}, 24'h3);
	endtask
	task automatic t_thresh();
		logic [4:0] codes [6];
		codes = '{5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h10};
		ROLE_I = LESC_ROLE_P2P_FDX;
		PROTO_STATE_I = LESC_ST_RUN;
		pulse(STATE_ENTER_I, 1);
		r = n_rep;
		pulse(REP_TX_I, 6);
		pulse(ACK_NEW_I, 1);
		pulse(REP_TX_I, 6);
		u_far.nak(`LESC_NAK_REP);
		cyc(2);
		chk(24'(n_rep - r), 24'h0);
		u_far.nak(`LESC_NAK_HDR_BCC);
		cyc(2);
		chk({21'(n_rep - r), rep_kind}, 24'h9);
		pulse(REP_TX_I, 6);
		cyc(2);
		chk(24'(n_rep - r), 24'h1);
		for (int i = 0; i < 13; i++) begin
			NAK_TX_REASON_I = (i == 6) ? `LESC_NAK_HDR_FORMAT : codes[i % 6];
			pulse(NAK_TX_I, 1);
			if (i == 5)
				pulse(GOOD_DATA_RX_I, 1);
		end
		cyc(2);
		chk(24'(n_rep - r), 24'h1);
		pulse(NAK_TX_I, 1);
		cyc(2);
		chk({21'(n_rep - r), rep_kind}, 24'h12);
		PROTO_STATE_I = LESC_ST_ISTRT;
		pulse(STATE_ENTER_I, 1);
		pulse(STRT_TX_I, 8);
		cyc(2);
		chk(24'(n_rep - r), 24'h3);
		PROTO_STATE_I = LESC_ST_ASTRT;
		pulse(STATE_ENTER_I, 1);
		pulse(STACK_TX_I, 7);
		cyc(2);
		chk(24'(n_rep - r), 24'h4);
	endtask
	initial begin
		repeat (4) @(posedge MCLK_I);
		#1 RESET_N_I = 1'b1;
		cyc(1);
		t_counts();
		t_select();
		t_station();
		t_thresh();
		DATA_RX_GOOD_I = 1'b1;
		pulse(DATA_TX_I, 65540);
		DATA_RX_GOOD_I = 1'b0;
		chk({DATA_TX_CNT_O, 8'h0}, 24'hFFFF00);
		chk(DATA_RX_CNT_O, 24'hFFFF);
		complete_run();
	end
	initial begin
		#400000;
		n_fail++;
		complete_run();
	end
endmodule
bind lesc_top lesc_checker u_chk (.*);
`default_nettype wire
